/* File: boot_source_select.sv */
// boot source selection and ROM init configuration record
`timescale 1ns/1ps
`default_nettype none
`include "boot_select_defines.svh"

module boot_source_select
#(
   parameter logic [7:0] INIT_LEN = `INIT_CYCLES
)
(
   // clock and resets
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               por_n,
   // pins
   input  wire logic               external_access_pin,
   input  wire logic               loader_strap_pin,
   input  wire logic               network_boot_strap_pin,
   // bypass bit write
   input  wire logic               bypass_wr,
   input  wire logic               bypass_wr_data,
   // progress from firmware
   input  wire logic               banner_sent,
   input  wire logic               network_boot_done,
   // fetch selection
   output logic [23:0]             fetch_addr,
   output logic                    fetch_from_rom,
   output logic                    rom_visible,
   output logic                    rom_bypass_bit,
   output boot_select_pkg::boot_path_t boot_path,
   output logic                    init_done,
   // serial loader
   output logic                    loader_listen,
   output logic                    loader_ready,
   // network boot
   output logic                    network_boot_active,
   output logic                    clock_doubler_en,
   // memory configuration
   output logic                    addr24_en,
   output logic [23:0]             rom_base,
   output logic [3:0]              memory_chip_enables,
   output logic [3:0]              mem_ce_size_mb,
   output logic [3:0]              peripheral_chip_enables,
   output logic [3:0]              upper_chip_enables,
   output logic                    merged_mem,
   output logic                    xram_relocated,
   output logic [23:0]             sram_base,
   output logic [23:0]             sram_last,
   output logic                    ext_stack_en,
   output logic [2:0]              external_data_move_stretch,
   output logic [1:0]              serial_mode
);

   import boot_select_pkg::*;

   //-------------------------------------------------------------------
   // parameter check
   //-------------------------------------------------------------------
   // a zero length would make the init count wrap around
   if (INIT_LEN == 8'h00)
   begin : g_bad_init
      $error("INIT_LEN must be at least one");
   end

   //-------------------------------------------------------------------
   // pin synchronisers
   //-------------------------------------------------------------------
   logic [2:0] pin_raw;
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   logic       access_s;
   logic       loader_s;
   logic       network_boot_s;

   // pins gathered so that one loop builds every synchroniser
   assign pin_raw = {network_boot_strap_pin, loader_strap_pin,
                     external_access_pin};

   // two flops per pin; only the second stage is read; every stage resets
   // high, and nothing is decided before real samples arrive
   for (genvar i = 0; i < $bits(pin_raw); i++)
   begin : g_sync
      always_ff @(posedge clk or negedge reset_n)
      begin
         if (!reset_n)
         begin
            pin_meta_reg[i] <= 1'b1;
            pin_sync_reg[i] <= 1'b1;
         end
         else
         begin
            pin_meta_reg[i] <= pin_raw[i];
            pin_sync_reg[i] <= pin_meta_reg[i];
         end
      end
   end

   assign access_s  = pin_sync_reg[0];
   assign loader_s  = pin_sync_reg[1];
   assign network_boot_s = pin_sync_reg[2];

   //-------------------------------------------------------------------
   // bypass bit, cleared by power-on only
   //-------------------------------------------------------------------
   bypass_hold u_bypass
   (
      .clk            (clk),
      .por_n          (por_n),
      .wr_en          (bypass_wr),
      .wr_data        (bypass_wr_data),
      .rom_bypass_bit (rom_bypass_bit)
   );

   //-------------------------------------------------------------------
   // boot sequencer
   //-------------------------------------------------------------------
   boot_state_t state_reg;
   boot_state_t state_next;
   boot_path_t  path_reg;
   boot_path_t  path_next;
   logic [7:0]  wait_reg;
   logic [7:0]  wait_next;
   logic        rom_reg;
   logic        rom_next;
   logic        dbl_reg;
   logic        dbl_next;
   logic        ready_reg;
   logic        ready_next;
   logic        cfg_reg;
   logic        cfg_next;

   // wait for the synchronisers to fill before reading the pins
   localparam logic [7:0] SYNC_WAIT = `SYNC_WAIT_CYCLES;

   // decision tree; straps read once, in order, then held
   always_comb
   begin
      state_next = state_reg;
      path_next  = path_reg;
      wait_next  = wait_reg;
      rom_next   = rom_reg;
      dbl_next   = dbl_reg;
      ready_next = ready_reg;
      unique case (state_reg)
         st_decide:
         begin
            if (wait_reg != SYNC_WAIT)
            begin
               wait_next = wait_reg + 8'h01;
            end
            else if (!access_s)
            begin
               // ROM stays hidden regardless of the bypass bit
               rom_next   = 1'b0;
               path_next  = path_external;
               state_next = st_run;
            end
            else if (rom_bypass_bit)
            begin
               rom_next   = 1'b0;
               path_next  = path_external;
               state_next = st_run;
            end
            else
            begin
               rom_next   = 1'b1;
               wait_next  = 8'h00;
               state_next = st_init;
            end
         end
         st_init:
         begin
            if (wait_reg != INIT_LEN - 8'h01)
            begin
               wait_next = wait_reg + 8'h01;
            end
            else if (loader_s)
            begin
               path_next  = path_loader;
               state_next = st_loader;
            end
            else if (!network_boot_s)
            begin
               path_next  = path_network_boot;
               state_next = st_network_boot;
            end
            else
            begin
               path_next  = path_search;
               state_next = st_run;
            end
         end
         st_loader:
         begin
            // commands only accepted once the banner is out
            if (banner_sent)
            begin
               ready_next = 1'b1;
            end
         end
         st_network_boot:
         begin
            if (network_boot_done)
            begin
               dbl_next   = 1'b1;
               state_next = st_run;
            end
         end
         st_run:
         begin
            // path and init settings stay put until the next reset
            state_next = st_run;
         end
         default:
         begin
            // illegal code: start the decision over
            state_next = st_decide;
         end
      endcase
      // init results show only once the ROM path has left init
      cfg_next = rom_next && (state_next != st_init)
                 && (state_next != st_decide);
   end

   // registered sequencer state
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= st_decide;
         path_reg  <= path_none;
         wait_reg  <= 8'h00;
         rom_reg   <= 1'b0;
         dbl_reg   <= 1'b0;
         ready_reg <= 1'b0;
         cfg_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         path_reg  <= path_next;
         wait_reg  <= wait_next;
         rom_reg   <= rom_next;
         dbl_reg   <= dbl_next;
         ready_reg <= ready_next;
         cfg_reg   <= cfg_next;
      end
   end

   //-------------------------------------------------------------------
   // output helpers
   //-------------------------------------------------------------------
   // chip-enable fields read as zero until the ROM init has set them
   function automatic logic [3:0] gate4
   (
      input logic       on,
      input logic [3:0] value
   );
      begin
         gate4 = on ? value : 4'h0;
      end
   endfunction

   //-------------------------------------------------------------------
   // outputs
   //-------------------------------------------------------------------
   logic rom_cfg;

   // registered flag, so the memory map does not hang off a state
   // decode; configuration only applies once the ROM path ran init
   assign rom_cfg = cfg_reg;

   // every reset restarts fetch at the bottom of the space
   assign fetch_addr     = `RESET_FETCH_ADDR;
   assign fetch_from_rom = rom_reg;
   assign rom_visible    = rom_reg && access_s;
   assign boot_path      = path_reg;
   assign init_done      = rom_cfg;

   assign loader_listen    = (state_reg == st_loader);
   assign loader_ready     = ready_reg;
   assign network_boot_active   = (state_reg == st_network_boot);
   assign clock_doubler_en = dbl_reg && !network_boot_active;

   // memory map produced by the ROM init
   assign addr24_en  = rom_cfg;
   assign rom_base   = rom_cfg ? `ROM_RELOC_BASE : 24'h000000;
   assign memory_chip_enables     = gate4(rom_cfg, `CE_ALL_ON);
   assign mem_ce_size_mb          = gate4(rom_cfg, `MEM_CE_SIZE_MB);
   assign peripheral_chip_enables = gate4(rom_cfg, `CE_ALL_ON);
   assign upper_chip_enables      = gate4(rom_cfg, `CE_ALL_ON);
   assign merged_mem     = rom_cfg;
   assign xram_relocated = rom_cfg;
   // SRAM window is fixed; the merged flag says when it applies
   assign sram_base = `SRAM_BASE;
   assign sram_last = `SRAM_LAST;
   assign ext_stack_en = rom_cfg;
   assign external_data_move_stretch =
      rom_cfg ? `EXT_MOVE_STRETCH_MAX : 3'h0;
   assign serial_mode = rom_cfg ? `SERIAL_MODE_ASYNC1 : 2'h0;

endmodule // boot_source_select

`default_nettype wire

/* File: boot_select_defines.svh */
// constants for the boot source selector
`ifndef BOOT_SELECT_DEFINES_SVH
`define BOOT_SELECT_DEFINES_SVH

//----------------------------------------------------------------------
// addresses
//----------------------------------------------------------------------
`define RESET_FETCH_ADDR   24'h000000
`define ROM_RELOC_BASE     24'hff0000
`define SRAM_BASE          24'h000000
`define SRAM_LAST          24'h00ffff

//----------------------------------------------------------------------
// init settings
//----------------------------------------------------------------------
`define MEM_CE_SIZE_MB     4'h2
`define EXT_MOVE_STRETCH_MAX 3'h7
`define SERIAL_MODE_ASYNC1 2'h1
`define CE_ALL_ON          4'hf

//----------------------------------------------------------------------
// timing
//----------------------------------------------------------------------
`define INIT_CYCLES        8'h04
`define SYNC_WAIT_CYCLES   8'h02

`endif

/* File: boot_select_pkg.sv */
// types for the boot source selector
package boot_select_pkg;

   //-------------------------------------------------------------------
   // boot path chosen after reset
   //-------------------------------------------------------------------
   typedef enum logic [2:0] {
      path_none     = 3'b000,
      path_external = 3'b001,
      path_loader   = 3'b010,
      path_network_boot  = 3'b011,
      path_search   = 3'b100
   } boot_path_t;

   //-------------------------------------------------------------------
   // sequencer states
   //-------------------------------------------------------------------
   typedef enum logic [2:0] {
      st_decide   = 3'b000,
      st_init     = 3'b001,
      st_loader   = 3'b010,
      st_network_boot  = 3'b011,
      st_run      = 3'b100
   } boot_state_t;

endpackage

/* File: bypass_hold.sv */
// bypass bit storage that only a power-on reset clears
`timescale 1ns/1ps
`default_nettype none
`include "boot_select_defines.svh"

module bypass_hold
(
   // clock and power-on reset
   input  wire logic clk,
   input  wire logic por_n,
   // software write
   input  wire logic wr_en,
   input  wire logic wr_data,
   // stored value
   output logic      rom_bypass_bit
);

   logic bypass_reg;
   logic bypass_next;

   // next value from software write only
   always_comb
   begin
      bypass_next = bypass_reg;
      if (wr_en)
      begin
         bypass_next = wr_data;
      end
   end

   // other resets do not reach this flop, so the value survives them
   always_ff @(posedge clk or negedge por_n)
   begin
      if (!por_n)
      begin
         bypass_reg <= 1'b0;
      end
      else
      begin
         bypass_reg <= bypass_next;
      end
   end

   assign rom_bypass_bit = bypass_reg;

endmodule // bypass_hold

`default_nettype wire

/* File: boot_select_props.sv */
// assertion checker for the boot source selector
`timescale 1ns/1ps
`default_nettype none
module boot_select_props
(
   // clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic por_n,
   // watched ports
   input wire logic external_access_pin,
   input wire logic bypass_wr,
   input wire logic network_boot_done,
   input wire logic [23:0] fetch_addr,
   input wire logic fetch_from_rom,
   input wire logic rom_visible,
   input wire logic rom_bypass_bit,
   input wire boot_select_pkg::boot_path_t boot_path,
   input wire logic init_done,
   input wire logic loader_listen,
   input wire logic network_boot_active,
   input wire logic clock_doubler_en,
   input wire logic [23:0] rom_base,
   input wire logic [3:0] memory_chip_enables,
   input wire logic [2:0] external_data_move_stretch,
   input wire logic [1:0] serial_mode
);
   import boot_select_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   //----------------------------------------------------------
   // properties
   //----------------------------------------------------------
   property p_fetch_zero;
      fetch_addr == 24'h000000;
   endproperty
   a_fetch_zero: assert property (p_fetch_zero)
      else $error("first fetch address is not zero");
   // two low samples flush the pin synchroniser; rom_visible is checked on the third
   property p_ea_low;
      !external_access_pin [*3] |-> !rom_visible;
   endproperty
   a_ea_low: assert property (p_ea_low)
      else $error("rom visible while access pin low");
   property p_rom_pick;
      $rose(fetch_from_rom) |-> !rom_bypass_bit;
   endproperty
   a_rom_pick: assert property (p_rom_pick)
      else $error("rom chosen with bypass bit set");
   // only power-on reset may touch the bit, so ordinary reset is watched
   property p_bypass_keep;
      disable iff (!por_n)
         !bypass_wr |=> rom_bypass_bit == $past(rom_bypass_bit);
   endproperty
   a_bypass_keep: assert property (p_bypass_keep)
      else $error("bypass bit changed without write");
   property p_path_fixed;
      boot_path != path_none |=> $stable(boot_path);
   endproperty
   a_path_fixed: assert property (p_path_fixed)
      else $error("boot path changed before reset");
   property p_no_doubler;
      network_boot_active |-> !clock_doubler_en;
   endproperty
   a_no_doubler: assert property (p_no_doubler)
      else $error("doubler on during network boot");
   property p_doubler_on;
      network_boot_active && network_boot_done |-> ##[1:2] clock_doubler_en;
   endproperty
   a_doubler_on: assert property (p_doubler_on)
      else $error("doubler not enabled after network boot");
   property p_init_cfg;
      init_done |-> rom_base == 24'hff0000 && memory_chip_enables == 4'hf
         && external_data_move_stretch == 3'h7 && serial_mode == 2'h1;
   endproperty
   a_init_cfg: assert property (p_init_cfg)
      else $error("init configuration wrong");
   property p_loader;
      loader_listen |-> boot_path == path_loader && init_done;
   endproperty
   a_loader: assert property (p_loader)
      else $error("loader listening off the loader path");
   c_loader: cover property (loader_listen);
   c_network_boot: cover property (network_boot_active ##1 clock_doubler_en);
   c_search: cover property (boot_path == path_search);
endmodule // boot_select_props
`default_nettype wire

/* File: board_model.sv */
// board model: strap pins and firmware progress replies
`timescale 1ns/1ps
`default_nettype none
module board_model
(
   // clock and bench settings
   input  wire logic       clk,
   input  wire logic [2:0] strap_cfg,
   input  wire logic [3:0] reply_dly,
   // device state seen
   input  wire logic       loader_listen,
   input  wire logic       network_boot_active,
   // pins and replies
   output logic            external_access_pin,
   output logic            loader_strap_pin,
   output logic            network_boot_strap_pin,
   output logic            banner_sent,
   output logic            network_boot_done
);
   //----------------------------------------------------------
   // replies
   //----------------------------------------------------------
   logic [3:0] wait_reg;
   // straps are static board levels, never released
   assign {external_access_pin, loader_strap_pin, network_boot_strap_pin} =
      strap_cfg;
   // delay counter lets replies come promptly or slowly
   always_ff @(posedge clk)
   begin
      if (!(loader_listen || network_boot_active))
         wait_reg <= 4'h0;
      else if (wait_reg != 4'hf)
         wait_reg <= wait_reg + 4'h1;
   end
   // host sends nothing until banner and prompt arrive
   assign banner_sent = loader_listen && wait_reg == reply_dly;
   assign network_boot_done = network_boot_active && wait_reg == reply_dly;
endmodule // board_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the boot source selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import boot_select_pkg::*;
   //----------------------------------------------------------
   // signals and tasks
   //----------------------------------------------------------
   logic clk = 1'b0, reset_n = 1'b0, por_n = 1'b0;
   logic bypass_wr = 1'b0, bypass_wr_data = 1'b0;
   logic [2:0] strap_cfg = 3'b101;
   logic [3:0] reply_dly = 4'h1;
   logic external_access_pin, loader_strap_pin, network_boot_strap_pin;
   logic banner_sent, network_boot_done, fetch_from_rom, rom_visible;
   logic rom_bypass_bit, init_done, loader_listen, loader_ready;
   logic network_boot_active, clock_doubler_en, addr24_en, merged_mem;
   logic xram_relocated, ext_stack_en;
   logic [23:0] fetch_addr, rom_base, sram_base, sram_last;
   logic [3:0] memory_chip_enables, mem_ce_size_mb;
   logic [3:0] peripheral_chip_enables, upper_chip_enables;
   logic [2:0] external_data_move_stretch;
   logic [1:0] serial_mode;
   boot_path_t boot_path;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   boot_source_select #(.INIT_LEN(8'h03)) dut_u (.*);
   board_model model_u (.*);
   always #12.5 clk = ~clk;
   task automatic chk(input string nm, input logic [23:0] e, g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // reset with given straps {access, loader, network_boot}
   task automatic boot(input logic [2:0] s, input logic por);
      @(posedge clk);
      strap_cfg <= s;
      reset_n <= 1'b0;
      por_n <= !por;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      por_n <= 1'b1;
      for (int i = 0; i < 30 && boot_path === path_none; i++)
         @(posedge clk);
      @(negedge clk);
   endtask
   task automatic set_bypass(input logic v);
      @(posedge clk);
      bypass_wr <= 1'b1;
      bypass_wr_data <= v;
      @(posedge clk);
      bypass_wr <= 1'b0;
      @(negedge clk);
   endtask
   // bounded wait on a device flag
   task automatic wait_for(ref logic s);
      for (int i = 0; i < 20 && s !== 1'b1; i++)
         @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // cycle ceiling well above the whole sequence
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   initial
   begin
      boot(3'b101, 1'b1);
      chk("path", 24'(path_search), 24'(boot_path));
      chk("rom", 24'h3, {rom_visible, fetch_from_rom});
      chk("fetch", 24'h0, fetch_addr);
      chk("base", 24'hff0000, rom_base);
      chk("ces", 24'hfff2, {memory_chip_enables, peripheral_chip_enables,
         upper_chip_enables, mem_ce_size_mb});
      chk("flags", 24'h1f, {init_done, addr24_en, merged_mem,
         xram_relocated, ext_stack_en});
      chk("modes", 24'h1d, {external_data_move_stretch,
         serial_mode});
      chk("sram base", 24'h000000, sram_base);
      chk("sram last", 24'h00ffff, sram_last);
      @(posedge clk);
      strap_cfg <= 3'b110;
      repeat (6) @(negedge clk);
      chk("held path", 24'(path_search), 24'(boot_path));
      $display("test search done");
      reply_dly <= 4'h6;
      boot(3'b110, 1'b0);
      chk("path", 24'(path_loader), 24'(boot_path));
      chk("listen", 24'h1, {network_boot_active, loader_listen});
      wait_for(loader_ready);
      chk("ready", 24'h1, loader_ready);
      $display("test loader done");
      reply_dly <= 4'h2;
      boot(3'b100, 1'b0);
      chk("path", 24'(path_network_boot), 24'(boot_path));
      chk("nb", 24'h2, {network_boot_active, clock_doubler_en});
      wait_for(clock_doubler_en);
      chk("doubler", 24'h1, clock_doubler_en);
      $display("test network_boot done");
      set_bypass(1'b1);
      boot(3'b110, 1'b0);
      chk("path", 24'(path_external), 24'(boot_path));
      chk("bypass", 24'h1, {fetch_from_rom, rom_bypass_bit});
      chk("no init", 24'h0, {init_done, addr24_en, memory_chip_enables});
      for (int v = 0; v < 2; v++)
      begin
         set_bypass(v[0]);
         boot(3'b011, 1'b0);
         chk("path", 24'(path_external), 24'(boot_path));
         chk("hidden", 24'h0, {rom_visible, fetch_from_rom});
      end
      $display("test external done");
      boot(3'b101, 1'b1);
      chk("por bypass", 24'h0, rom_bypass_bit);
      chk("path", 24'(path_search), 24'(boot_path));
      $display("test power-on done");
      print_verdict();
   end
endmodule // testbench
bind boot_source_select boot_select_props chk_u (.*);
`default_nettype wire
